// ---- csamp_pkg.sv ----
package csamp_pkg;

  // Gain codes
  localparam logic [2:0] GAIN_CODE_RESET = 3'h0;
  localparam int         GAIN_W          = 3;

  // Auto-zero mode encoding
  typedef enum logic [1:0] {
    AZ_DISABLED = 2'b00,
    AZ_INTERNAL = 2'b01,
    AZ_EXTERNAL = 2'b10,
    AZ_EXT_GATE = 2'b11
  } az_mode_t;

  // Timing, clock at 10 MHz
  localparam int CLK_HZ          = 10_000_000;
  localparam int AZ_MIN_US       = 200;
  localparam int AZ_MIN_CAL_US   = 100;
  localparam int AZ_SYNC_MIN_US  = 100;
  localparam int AZ_CYCLE_US     = 400;
  localparam int AZ_DUR_US       = 2;
  localparam int AZ_MIN_CYC      = AZ_MIN_US * (CLK_HZ / 1_000_000);
  localparam int AZ_MIN_CAL_CYC  = AZ_MIN_CAL_US * (CLK_HZ / 1_000_000);
  localparam int AZ_SYNC_MIN_CYC = AZ_SYNC_MIN_US * (CLK_HZ / 1_000_000);
  localparam int AZ_CYCLE_CYC    = AZ_CYCLE_US * (CLK_HZ / 1_000_000);
  localparam int AZ_DUR_CYC      = AZ_DUR_US * (CLK_HZ / 1_000_000);
  localparam int TMR_W           = 13;
  // Edge flops read real pin levels only after this many cycles out of reset
  localparam logic [1:0] SYNC_FILL_CNT = 2'h3;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_STARTUP = 2'b01,
    ST_ACTIVE  = 2'b10
  } drv_state_t;

endpackage

// ---- sync2.sv ----
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- csamp_gain_cal_autozero_ctrl.sv ----
// Functional notes
// - Digital gain code 0..7 selects gain 4,8,12,16,20,24,32,64.
// - In resistor mode, gain is latched once at start-up from the resistor code.
// - Gain in effect is reported on a readback field.
// - Calibration shorts amplifier inputs only while active with drive enable high.
// - Clearing calibration enable reconnects inputs to sense pins.
// - Auto-zero minimum interval 200 us, 100 us during calibration; in external modes a sync pin fall starts one at any interval.
// - Auto-zero shorts inputs and holds outputs for the auto-zero duration.
// - Disabled mode suppresses all auto-zero.
// - Internal mode starts on first gate rising edge after 200 us, 100 us during calibration.
// - Auto-zero runs from drive enable until pump undervoltage releases.
// - Internal mode watchdog forces auto-zero after maximum interval without edge.
// - Auto-zero continues in standby.
// - External mode ignores gate edges, triggers on sync pin falling edge.
// - Gated mode stops pump clock from sync rise to auto-zero end and pin fall.
// - Pump undervoltage protection stays enabled while pump clock is gated.
// - Drive enable low is standby, high is active operation.
`timescale 1ns/10ps
`default_nettype none
module csamp_gain_cal_autozero_ctrl
  import csamp_pkg::*;
#(
  parameter int NUM_AMP = 3
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Configuration
  input  wire logic [GAIN_W-1:0]  gain_code,
  input  wire logic               analog_gain_select,
  input  wire logic               dc_cal_enable,
  input  wire logic [1:0]         autozero_mode_field,
  // Pins and analog status
  input  wire logic               drive_enable_pin,
  input  wire logic               gain_sync_pin,
  input  wire logic [NUM_AMP-1:0] high_side_gate_out,
  input  wire logic [GAIN_W-1:0]  rgain_code,
  input  wire logic               pump_uv_low_side,
  input  wire logic               pump_uv_high_side,
  // Amplifier controls
  output logic      [GAIN_W-1:0]  gain_sel_q,
  output logic      [GAIN_W-1:0]  gain_readback_field_q,
  output logic      [NUM_AMP-1:0] amp_short_q,
  output logic      [NUM_AMP-1:0] amp_hold_q,
  output logic                    cal_active_q,
  output logic                    pump_clk_gate_q,
  output logic                    pump_uvlo_en_q,
  output logic                    active_q
);

  // Hold and short vectors are replicated per amplifier; more than eight is not served
  if (NUM_AMP < 1 || NUM_AMP > 8) begin : g_bad_num_amp
    $error("NUM_AMP out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = NUM_AMP + 4;
  logic [SW-1:0] raw_in;
  logic [SW-1:0] syn;
  assign raw_in = {high_side_gate_out, pump_uv_high_side, pump_uv_low_side,
                   gain_sync_pin, drive_enable_pin};

  sync2 #(.W(SW)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (raw_in),
    .q      (syn)
  );

  wire               en_s   = syn[0];
  wire               gs_s   = syn[1];
  wire               uv_any = syn[2] | syn[3];
  wire [NUM_AMP-1:0] gh_s   = syn[SW-1:4];

  // Edges are masked until the synchroniser and the edge flop hold real pin levels,
  // otherwise an idle-high sync pin looks like a rising edge right after reset
  logic [1:0]         settle_q;
  wire                edges_ok = (settle_q == SYNC_FILL_CNT);
  logic               gs_prev_q;
  logic [NUM_AMP-1:0] gh_prev_q;
  wire                gs_fall = edges_ok & gs_prev_q & ~gs_s;
  wire                gs_rise = edges_ok & ~gs_prev_q & gs_s;
  wire [NUM_AMP-1:0]  gh_rise = {NUM_AMP{edges_ok}} & gh_s & ~gh_prev_q;

  // ----------------------------------------------------------------
  // Drive state
  // ----------------------------------------------------------------
  drv_state_t state_q;
  drv_state_t state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STANDBY: if (en_s) state_d = ST_STARTUP;
      ST_STARTUP: if (!en_s) state_d = ST_STANDBY;
                  else if (!uv_any) state_d = ST_ACTIVE;
      ST_ACTIVE:  if (!en_s) state_d = ST_STANDBY;
      default:    state_d = ST_STANDBY;
    endcase
  end

  wire in_startup = (state_q == ST_STARTUP);
  wire is_active  = (state_q == ST_ACTIVE);

  // ----------------------------------------------------------------
  // Gain selection
  // ----------------------------------------------------------------
  logic [GAIN_W-1:0] rgain_q;
  logic              rgain_done_q;
  wire               rgain_take = in_startup & ~rgain_done_q;
  // Resistor is read once per power-up; later start-ups keep the first reading
  wire [GAIN_W-1:0]  gain_eff = analog_gain_select ? rgain_q : gain_code;

  // ----------------------------------------------------------------
  // Calibration
  // ----------------------------------------------------------------
  wire cal_on = dc_cal_enable & is_active & en_s;

  // ----------------------------------------------------------------
  // Auto-zero
  // ----------------------------------------------------------------
  az_mode_t mode;
  assign mode = az_mode_t'(autozero_mode_field);

  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] dur_q;
  logic             az_q;
  logic             gate_wait_q;

  wire [TMR_W-1:0] min_cyc = cal_on ? TMR_W'(AZ_MIN_CAL_CYC) : TMR_W'(AZ_MIN_CYC);
  wire [TMR_W-1:0] sync_cyc = (TMR_W'(AZ_SYNC_MIN_CYC) > min_cyc) ?
                              TMR_W'(AZ_SYNC_MIN_CYC) : min_cyc;
  wire min_ok   = tmr_q >= sync_cyc;
  wire wd_hit   = tmr_q >= TMR_W'(AZ_CYCLE_CYC - 1);
  wire int_trig = (mode == AZ_INTERNAL) & min_ok & ((|gh_rise) | wd_hit);
  wire ext_mode = (mode == AZ_EXTERNAL) | (mode == AZ_EXT_GATE);
  wire ext_trig = ext_mode & gs_fall;
  wire su_trig  = in_startup & min_ok;
  wire az_start = ~az_q & (mode != AZ_DISABLED) & (int_trig | ext_trig | su_trig);
  wire az_end   = az_q & (dur_q == TMR_W'(AZ_DUR_CYC - 1));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= ST_STANDBY;
      settle_q     <= '0;
      gs_prev_q    <= 1'b0;
      gh_prev_q    <= '0;
      rgain_q      <= GAIN_CODE_RESET;
      rgain_done_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      if (!edges_ok) begin
        settle_q <= settle_q + 2'h1;
      end
      gs_prev_q <= gs_s;
      gh_prev_q <= gh_s;
      if (rgain_take) begin
        rgain_q      <= rgain_code;
        rgain_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_q <= '0;
      dur_q <= '0;
      az_q  <= 1'b0;
    end else begin
      if (az_start) begin
        az_q  <= 1'b1;
        dur_q <= '0;
      end else if (az_end) begin
        az_q  <= 1'b0;
        tmr_q <= '0;
      end else if (az_q) begin
        dur_q <= dur_q + TMR_W'(1);
      end else if (!wd_hit) begin
        tmr_q <= tmr_q + TMR_W'(1);
      end
    end
  end

  // Gate opens on pin rise; released once the period ends with the pin low, or at once when gated mode is left
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_wait_q     <= 1'b0;
      pump_clk_gate_q <= 1'b0;
    end else if (mode != AZ_EXT_GATE) begin
      gate_wait_q     <= 1'b0;
      pump_clk_gate_q <= 1'b0;
    end else begin
      if (gs_rise) begin
        pump_clk_gate_q <= 1'b1;
        gate_wait_q     <= 1'b1;
      end else if (gate_wait_q && az_end && !gs_s) begin
        pump_clk_gate_q <= 1'b0;
        gate_wait_q     <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_sel_q            <= GAIN_CODE_RESET;
      gain_readback_field_q <= GAIN_CODE_RESET;
      amp_short_q           <= '0;
      amp_hold_q            <= '0;
      cal_active_q          <= 1'b0;
      pump_uvlo_en_q        <= 1'b1;
      active_q              <= 1'b0;
    end else begin
      gain_sel_q            <= gain_eff;
      gain_readback_field_q <= gain_eff;
      amp_short_q           <= {NUM_AMP{cal_on | az_start | (az_q & ~az_end)}};
      amp_hold_q            <= {NUM_AMP{az_start | (az_q & ~az_end)}};
      cal_active_q          <= cal_on;
      pump_uvlo_en_q        <= 1'b1;
      active_q              <= is_active;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_disabled_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == AZ_DISABLED) |-> !az_start)
    else $error("auto-zero started while disabled");

  a_cal_needs_en: assert property (@(posedge clk) disable iff (!arst_n)
    cal_active_q |-> $past(is_active))
    else $error("calibration outside active state");

  a_az_hold_len: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(az_q) |-> az_q [*8])
    else $error("auto-zero period too short");

  a_timer_restart: assert property (@(posedge clk) disable iff (!arst_n)
    az_end |=> (tmr_q == '0))
    else $error("interval timer not restarted");

  a_ext_no_gh: assert property (@(posedge clk) disable iff (!arst_n)
    (ext_mode && !gs_fall && !in_startup) |-> !az_start)
    else $error("external mode started without pin fall");

  a_min_interval: assert property (@(posedge clk) disable iff (!arst_n)
    (az_start && !ext_mode) |-> (tmr_q >= TMR_W'(AZ_MIN_CAL_CYC)))
    else $error("auto-zero interval too short");

  a_uvlo_kept: assert property (@(posedge clk) disable iff (!arst_n)
    pump_clk_gate_q |-> pump_uvlo_en_q)
    else $error("undervoltage off while pump gated");

  a_readback_gain: assert property (@(posedge clk) disable iff (!arst_n)
    gain_readback_field_q == gain_sel_q)
    else $error("readback differs from gain in effect");

  a_cal_release: assert property (@(posedge clk) disable iff (!arst_n)
    (!dc_cal_enable && !az_q && !az_start) |=> !amp_short_q[0])
    else $error("inputs not reconnected after calibration");

  a_hold_length: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(amp_hold_q[0]) |-> ($past(dur_q) == TMR_W'(AZ_DUR_CYC - 1)))
    else $error("auto-zero hold ended at wrong length");

  a_int_edge_start: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == AZ_INTERNAL) && (|gh_rise) && min_ok && !az_q) |=> amp_hold_q[0])
    else $error("gate edge after interval did not start auto-zero");

  a_wd_force: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == AZ_INTERNAL) && wd_hit && !az_q) |=> amp_hold_q[0])
    else $error("watchdog did not force auto-zero");

  a_ext_fall_start: assert property (@(posedge clk) disable iff (!arst_n)
    (ext_mode && gs_fall && !az_q) |=> amp_hold_q[0])
    else $error("sync pin fall did not start auto-zero");

  a_startup_az: assert property (@(posedge clk) disable iff (!arst_n)
    (in_startup && min_ok && !az_q && (mode != AZ_DISABLED)) |=> amp_hold_q[0])
    else $error("no auto-zero during start-up");

  a_cal_shorts: assert property (@(posedge clk) disable iff (!arst_n)
    cal_on |=> (amp_short_q == {NUM_AMP{1'b1}}))
    else $error("calibration did not short inputs");

  a_gate_held: assert property (@(posedge clk) disable iff (!arst_n)
    (pump_clk_gate_q && (mode == AZ_EXT_GATE) && !az_end) |=> pump_clk_gate_q)
    else $error("pump clock released before period end");

  a_gate_mode_off: assert property (@(posedge clk) disable iff (!arst_n)
    (mode != AZ_EXT_GATE) |=> !pump_clk_gate_q)
    else $error("pump clock gated outside gating mode");

endmodule
`default_nettype wire

// ---- mcu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mcu_model (
  // Clock
  input  wire logic       clk,
  // Pins toward the driver
  output var  logic       en,
  output var  logic       sync,
  output var  logic [2:0] gate
);
  // Sync idles high so its first fall is a deliberate trigger
  initial begin
    en   = 1'b0;
    sync = 1'b1;
    gate = 3'h0;
  end
  task automatic set_en(input logic v);
    @(negedge clk) en = v;
  endtask
  task automatic set_sync(input logic v);
    @(negedge clk) sync = v;
  endtask
  task automatic set_gates(input logic [2:0] v);
    @(negedge clk) gate = v;
  endtask
endmodule
`default_nettype wire

// ---- csamp_gain_cal_autozero_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module csamp_gain_cal_autozero_ctrl_tb
  import csamp_pkg::*;
;
  logic       clk, arst_n, ags, cal, uvl, uvh;
  logic [2:0] gcode, rcode, gsel, grb, sh, hd;
  logic       calq, pg, uvlo, act;
  az_mode_t   mode;
  wire logic  en, sync;
  wire logic [2:0] gate;
  int         error_cnt, compares;

  mcu_model mcu (.clk(clk), .en(en), .sync(sync), .gate(gate));

  csamp_gain_cal_autozero_ctrl dut (
    .clk(clk), .arst_n(arst_n), .gain_code(gcode),
    .analog_gain_select(ags), .dc_cal_enable(cal),
    .autozero_mode_field(mode), .drive_enable_pin(en),
    .gain_sync_pin(sync), .high_side_gate_out(gate),
    .rgain_code(rcode), .pump_uv_low_side(uvl),
    .pump_uv_high_side(uvh), .gain_sel_q(gsel),
    .gain_readback_field_q(grb), .amp_short_q(sh),
    .amp_hold_q(hd), .cal_active_q(calq),
    .pump_clk_gate_q(pg), .pump_uvlo_en_q(uvlo), .active_q(act)
  );

  // ------------------------------
  // Checking helpers
  // ------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic set_cfg(input az_mode_t m, input logic a, input logic c);
    mode = m;
    ags  = a;
    cal  = c;
  endtask

  task automatic set_uv(input logic l, input logic h);
    uvl = l;
    uvh = h;
  endtask

  // Reset is held for four cycles; the resistor code stands in for the board fitted
  task automatic apply_reset(input logic [2:0] r);
    arst_n = 1'b0;
    rcode  = r;
    repeat (4) @(negedge clk);
    chk({calq, pg, uvlo, act, 1'b0, sh}, 8'h20);
    arst_n = 1'b1;
  endtask

  // Waits up to n cycles for a period; a missing expected one ends the run
  task automatic az_within(input int n, input logic exp);
    int i;
    int len;
    len = 0;
    for (i = 0; i < n && hd === 3'h0; i++) @(negedge clk);
    if (hd !== 3'h0) begin
      chk({7'h0, sh === 3'h7}, 8'h01);
      while (hd !== 3'h0 && len < 40) begin
        len++;
        @(negedge clk);
      end
    end
    chk({7'h0, len != 0}, {7'h0, exp});
    if (exp) chk(len[7:0], AZ_DUR_CYC[7:0]);
    if (exp && len == 0) tally_and_finish();
  endtask

  // ------------------------------
  // Clock and hang limit
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #5_000_000;
    error_cnt++;
    tally_and_finish();
  end

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    error_cnt = 0;
    compares  = 0;
    gcode     = 3'h2;
    set_cfg(AZ_INTERNAL, 1'b1, 1'b0);
    set_uv(1'b1, 1'b1);
    apply_reset(3'h5);
    mcu.set_en(1'b1);
    az_within(2200, 1'b1);
    chk({7'h0, act}, 8'h00);
    // One rail still under voltage keeps the start-up going
    set_uv(1'b0, 1'b1);
    repeat (10) @(negedge clk);
    chk({7'h0, act}, 8'h00);
    set_uv(1'b0, 1'b0);
    repeat (10) @(negedge clk);
    chk({7'h0, act}, 8'h01);
    chk({2'h0, gsel, grb}, 8'h2D);
    set_cfg(AZ_INTERNAL, 1'b0, 1'b0);
    for (int c = 0; c < 8; c++) begin
      gcode = c[2:0];
      repeat (2) @(negedge clk);
      chk({2'h0, gsel, grb}, {2'h0, c[2:0], c[2:0]});
    end
    set_cfg(AZ_DISABLED, 1'b0, 1'b0);
    az_within(4200, 1'b0);
    set_cfg(AZ_INTERNAL, 1'b0, 1'b0);
    az_within(4100, 1'b1);
    // Too early after the last period: the edge must be ignored
    repeat (1100) @(negedge clk);
    mcu.set_gates(3'h7);
    az_within(10, 1'b0);
    mcu.set_gates(3'h0);
    az_within(1000, 1'b0);
    mcu.set_gates(3'h7);
    az_within(10, 1'b1);
    mcu.set_gates(3'h0);
    set_cfg(AZ_INTERNAL, 1'b0, 1'b1);
    repeat (3) @(negedge clk);
    chk({4'h0, calq, sh}, 8'h0F);
    az_within(1060, 1'b0);
    mcu.set_gates(3'h7);
    az_within(10, 1'b1);
    mcu.set_gates(3'h0);
    set_cfg(AZ_INTERNAL, 1'b0, 1'b0);
    repeat (3) @(negedge clk);
    chk({4'h0, calq, sh}, 8'h00);
    mcu.set_en(1'b0);
    repeat (10) @(negedge clk);
    chk({7'h0, act}, 8'h00);
    set_cfg(AZ_INTERNAL, 1'b0, 1'b1);
    az_within(4100, 1'b1);
    chk({4'h0, calq, sh}, 8'h00);
    set_cfg(AZ_EXTERNAL, 1'b0, 1'b0);
    mcu.set_gates(3'h7);
    az_within(300, 1'b0);
    mcu.set_gates(3'h0);
    mcu.set_sync(1'b0);
    az_within(10, 1'b1);
    set_cfg(AZ_EXT_GATE, 1'b0, 1'b0);
    mcu.set_sync(1'b1);
    repeat (6) @(negedge clk);
    chk({6'h0, pg, uvlo}, 8'h03);
    mcu.set_sync(1'b0);
    az_within(10, 1'b1);
    repeat (2) @(negedge clk);
    chk({6'h0, pg, uvlo}, 8'h01);
    // Second power-up: the new resistor code is taken, the digital code (7) ignored
    set_cfg(AZ_INTERNAL, 1'b1, 1'b0);
    set_uv(1'b1, 1'b1);
    mcu.set_sync(1'b1);
    apply_reset(3'h6);
    mcu.set_en(1'b1);
    repeat (10) @(negedge clk);
    chk({7'h0, act}, 8'h00);
    set_uv(1'b0, 1'b0);
    repeat (10) @(negedge clk);
    chk({7'h0, act}, 8'h01);
    chk({2'h0, gsel, grb}, 8'h36);
    tally_and_finish();
  end
endmodule
`default_nettype wire
